/* File: estx_pkg.sv */
// package for the extended skip / table / xor execution block
// assumes a core with 8-bit data, 16-bit program words, 8-bit table pointers
package estx_pkg;

  // ----------------------------------------
  // widths and reset values
  // ----------------------------------------
  localparam int DW = 8;
  localparam int PW = 16;
  localparam int AW = 16;
  localparam logic [DW-1:0] ACC_RST  = 8'h00;
  localparam logic [DW-1:0] TABLE_READ_HIGH_BYTE_RST = 8'h00;
  localparam logic [DW-1:0] TABLE_POINTER_LOW_RST = 8'h00;
  // high byte of the last program page; a plain default, set per memory size
  localparam logic [7:0] LAST_PAGE = 8'hff;

  // ----------------------------------------
  // operation codes
  // ----------------------------------------
  typedef enum logic [3:0] {
    OP_NONE        = 4'h0,
    OP_SKIP_ZCOPY  = 4'h1,
    OP_SKIP_BIT    = 4'h2,
    OP_TAB_CUR     = 4'h3,
    OP_TAB_LAST    = 4'h4,
    OP_TAB_INC     = 4'h5,
    OP_TAB_INC_LST = 4'h6,
    OP_XOR_ACC     = 4'h7,
    OP_XOR_MEM     = 4'h8
  } estx_op_t;

  // ----------------------------------------
  // execution states
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_TABRD = 3'b010,
    ST_DUMMY = 3'b100
  } estx_state_t;

endpackage

/* File: estx_exec.sv */
// execution unit for byte/bit skips, table reads and xor operations
// assumes decode presents op, operand byte and bit index with op_valid_in
// for one cycle; program memory answers a read in the cycle its read strobe is high.
module estx_exec
  import estx_pkg::*;
(
  input  wire logic                    ref_clk_in,
  input  wire logic                    rst_in,
  input  wire logic                    op_valid_in,
  input  wire estx_pkg::estx_op_t      op_in,
  input  wire logic [estx_pkg::DW-1:0] mem_data_in,
  input  wire logic [2:0]              bit_sel_in,
  input  wire logic [7:0]              pc_page_in,
  input  wire logic [estx_pkg::DW-1:0] table_pointer_high_in,
  input  wire logic [estx_pkg::PW-1:0] prog_data_in,
  output logic [estx_pkg::DW-1:0]      accumulator_reg_out,
  output logic [estx_pkg::DW-1:0]      table_read_high_byte_out,
  output logic [estx_pkg::DW-1:0]      table_pointer_low_out,
  output logic                         zero_flag_out,
  output logic                         zero_flag_we_out,
  output logic [estx_pkg::DW-1:0]      mem_wdata_out,
  output logic                         mem_we_out,
  output logic [estx_pkg::AW-1:0]      prog_addr_out,
  output logic                         prog_rd_out,
  output logic                         fetch_kill_out,
  output logic                         busy_out
);
  import estx_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  estx_state_t   state_r;
  estx_state_t   state_nxt;
  logic [DW-1:0] xor_val;
  logic [DW-1:0] tpl_nxt;
  logic          take;
  logic          skip_now;
  logic          tab_now;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic is_zero(input logic [DW-1:0] v);
    return v == '0;
  endfunction

  // one decode shared by the sequencer, busy and the program access
  function automatic logic is_table_op(input estx_op_t op);
    return op inside {OP_TAB_CUR, OP_TAB_LAST, OP_TAB_INC, OP_TAB_INC_LST};
  endfunction

  // low byte only; the carry is dropped so the high pointer never moves
  function automatic logic [DW-1:0] bump_low(input logic [DW-1:0] v);
    return v + 8'h01;
  endfunction

  // an op is taken only while idle; one offered while busy is dropped
  assign take     = op_valid_in && (state_r == ST_IDLE);
  assign xor_val  = accumulator_reg_out ^ mem_data_in;
  assign tpl_nxt  = bump_low(table_pointer_low_out);
  assign tab_now  = take && is_table_op(op_in);
  assign skip_now = take &&
                    ((op_in == OP_SKIP_ZCOPY && is_zero(mem_data_in)) ||
                     (op_in == OP_SKIP_BIT && !mem_data_in[bit_sel_in]));

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  // a table read holds the pipeline one cycle for the program memory access
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (skip_now) begin
          state_nxt = ST_DUMMY;
        end else if (tab_now) begin
          state_nxt = ST_TABRD;
        end
      end
      ST_TABRD: begin
        state_nxt = ST_IDLE;
      end
      ST_DUMMY: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // the dummy slot: decode must swap the next fetched word for a no-op
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      fetch_kill_out <= 1'b0;
    end else begin
      fetch_kill_out <= skip_now;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      busy_out <= 1'b0;
    end else begin
      busy_out <= skip_now || tab_now;
    end
  end

  // ----------------------------------------
  // table pointer and program access
  // ----------------------------------------
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      table_pointer_low_out <= TABLE_POINTER_LOW_RST;
    end else begin
      if (take && (op_in == OP_TAB_INC || op_in == OP_TAB_INC_LST)) begin
        table_pointer_low_out <= tpl_nxt;
      end
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      prog_rd_out <= 1'b0;
    end else begin
      prog_rd_out <= tab_now;
    end
  end

  // the pre-incremented reads use the new low byte in the same cycle
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      prog_addr_out <= '0;
    end else begin
      if (take) begin
        unique case (op_in)
          OP_TAB_CUR: begin
            prog_addr_out <= {pc_page_in, table_pointer_low_out};
          end
          OP_TAB_LAST: begin
            prog_addr_out <= {LAST_PAGE, table_pointer_low_out};
          end
          OP_TAB_INC: begin
            prog_addr_out <= {table_pointer_high_in, tpl_nxt};
          end
          OP_TAB_INC_LST: begin
            prog_addr_out <= {LAST_PAGE, tpl_nxt};
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // results
  // ----------------------------------------
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      accumulator_reg_out <= ACC_RST;
    end else begin
      if (take && op_in == OP_SKIP_ZCOPY) begin
        // copied whether or not the skip is taken
        accumulator_reg_out <= mem_data_in;
      end else if (take && op_in == OP_XOR_ACC) begin
        accumulator_reg_out <= xor_val;
      end
    end
  end

  // program word is sampled at the end of the cycle the read strobe is high
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      table_read_high_byte_out <= TABLE_READ_HIGH_BYTE_RST;
    end else begin
      if (state_r == ST_TABRD) begin
        table_read_high_byte_out <= prog_data_in[PW-1:DW];
      end
    end
  end

  // only the xor ops touch the zero flag; skips and table reads leave it
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      zero_flag_out    <= 1'b0;
      zero_flag_we_out <= 1'b0;
    end else begin
      zero_flag_we_out <= 1'b0;
      if (take && (op_in == OP_XOR_ACC || op_in == OP_XOR_MEM)) begin
        zero_flag_out    <= is_zero(xor_val);
        zero_flag_we_out <= 1'b1;
      end
    end
  end

  // table low byte and xor-to-memory never collide: a table read is busy
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      mem_wdata_out <= '0;
      mem_we_out    <= 1'b0;
    end else begin
      mem_we_out <= 1'b0;
      if (state_r == ST_TABRD) begin
        mem_wdata_out <= prog_data_in[DW-1:0];
        mem_we_out    <= 1'b1;
      end else if (take && op_in == OP_XOR_MEM) begin
        mem_wdata_out <= xor_val;
        mem_we_out    <= 1'b1;
      end
    end
  end

endmodule // estx_exec

/* File: estx_exec_checker.sv */
// assertions on the ports of the skip / table / xor execution block
// assumes a bind onto estx_exec; one clock domain, async active-high reset
module estx_exec_checker
  import estx_pkg::*;
(
  input wire logic        ref_clk_in, rst_in, op_valid_in, zero_flag_out, zero_flag_we_out, mem_we_out,
  input wire logic        prog_rd_out, fetch_kill_out, busy_out,
  input wire estx_pkg::estx_op_t op_in,
  input wire logic [7:0]  mem_data_in, pc_page_in, table_pointer_high_in, accumulator_reg_out,
  input wire logic [7:0]  table_read_high_byte_out, table_pointer_low_out, mem_wdata_out,
  input wire logic [2:0]  bit_sel_in,
  input wire logic [15:0] prog_data_in, prog_addr_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import estx_pkg::*;
  // ------------------------------
  // properties
  // ------------------------------
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  wire go    = op_valid_in && !busy_out;
  wire sel_b = mem_data_in[bit_sel_in];
  property p_zc; go && op_in == OP_SKIP_ZCOPY |=> accumulator_reg_out == $past(mem_data_in)
    && fetch_kill_out == ($past(mem_data_in) == 8'h00); endproperty
  a_zc: assert property (p_zc) else $error("zero copy skip wrong");
  property p_kill; fetch_kill_out |-> busy_out ##1 !busy_out && !fetch_kill_out; endproperty
  a_kill: assert property (p_kill) else $error("dummy cycle length wrong");
  property p_bit; go && op_in == OP_SKIP_BIT |=> fetch_kill_out == !$past(sel_b) && !zero_flag_we_out; endproperty
  a_bit: assert property (p_bit) else $error("bit skip wrong");
  property p_data; go && op_in inside {[OP_TAB_CUR:OP_TAB_INC_LST]} |=> prog_rd_out ##1 mem_we_out
    && {table_read_high_byte_out, mem_wdata_out} == $past(prog_data_in); endproperty
  a_data: assert property (p_data) else $error("table word split wrong");
  property p_cur; go && op_in == OP_TAB_CUR |=> prog_addr_out == {$past(pc_page_in), table_pointer_low_out}; endproperty
  a_cur: assert property (p_cur) else $error("current page address wrong");
  property p_last; go && op_in == OP_TAB_LAST |=> prog_addr_out == {LAST_PAGE, table_pointer_low_out}; endproperty
  a_last: assert property (p_last) else $error("last page address wrong");
  property p_inc; go && op_in == OP_TAB_INC |=> prog_addr_out == {$past(table_pointer_high_in),
    $past(table_pointer_low_out) + 8'h01}; endproperty
  a_inc: assert property (p_inc) else $error("preinc address wrong");
  property p_incl; go && op_in == OP_TAB_INC_LST |=> prog_addr_out == {LAST_PAGE,
    $past(table_pointer_low_out) + 8'h01}; endproperty
  a_incl: assert property (p_incl) else $error("preinc last page address wrong");
  property p_xa; go && op_in == OP_XOR_ACC |=> accumulator_reg_out == ($past(accumulator_reg_out) ^ $past(mem_data_in))
    && zero_flag_we_out && zero_flag_out == (accumulator_reg_out == 8'h00) && !mem_we_out; endproperty
  a_xa: assert property (p_xa) else $error("xor to acc wrong");
  property p_xm; go && op_in == OP_XOR_MEM |=> mem_we_out && mem_wdata_out == ($past(accumulator_reg_out)
    ^ $past(mem_data_in)) && zero_flag_out == (mem_wdata_out == 8'h00) && $stable(accumulator_reg_out); endproperty
  a_xm: assert property (p_xm) else $error("xor to memory wrong");
  c_skip: cover property (fetch_kill_out);
  c_tab: cover property (mem_we_out && !zero_flag_we_out);
  c_xor: cover property (zero_flag_we_out && zero_flag_out);
endmodule // estx_exec_checker
bind estx_exec estx_exec_checker u_chk (.*);

/* File: estx_exec_tb_top.sv */
// directed bench for the skip / table / xor execution block
// assumes the bench plays decode and program memory, driving at falling edges
module estx_exec_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import estx_pkg::*;
  logic ref_clk_in = 0, rst_in = 1, op_valid_in = 0;
  estx_op_t op_in = OP_NONE;
  logic [7:0] mem_data_in = 0, pc_page_in = 0, table_pointer_high_in = 0, accumulator_reg_out;
  logic [7:0] table_read_high_byte_out, table_pointer_low_out, mem_wdata_out;
  logic [2:0] bit_sel_in = 0;
  logic [15:0] prog_data_in = 0, prog_addr_out;
  logic zero_flag_out, zero_flag_we_out, mem_we_out, prog_rd_out, fetch_kill_out, busy_out;
  int error_cnt = 0, checked = 0;
  always #5 ref_clk_in = ~ref_clk_in;
  estx_exec u_dut (.*);
  task chk(string n, logic [15:0] e, logic [15:0] s);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  // one-cycle request; returns mid-cycle after the answer edge
  task go(estx_op_t o, logic [7:0] d, logic [2:0] b);
    @(negedge ref_clk_in);
    op_valid_in = 1; op_in = o; mem_data_in = d; bit_sel_in = b;
    @(negedge ref_clk_in);
    op_valid_in = 0; mem_data_in = ~d;
  endtask
  task tab(estx_op_t o, logic [15:0] ea, logic [15:0] w);
    go(o, 8'h00, 3'h0);
    chk("addr", ea, prog_addr_out);
    chk("rd", 1, prog_rd_out);
    prog_data_in = w;
    @(negedge ref_clk_in);
    chk("wdata", w[7:0], mem_wdata_out);
    chk("table_read_high_byte", w[15:8], table_read_high_byte_out);
    chk("we", 1, mem_we_out);
    prog_data_in = ~w;
  endtask
  task t_skip;
    go(OP_SKIP_ZCOPY, 8'h00, 3'h0); chk("kill", 1, fetch_kill_out);
    chk("acc", 8'h00, accumulator_reg_out); chk("busy", 1, busy_out);
    // an op offered in the dummy slot must be dropped
    op_valid_in = 1;
    op_in = OP_XOR_ACC;
    mem_data_in = 8'hff;
    @(negedge ref_clk_in);
    op_valid_in = 0;
    chk("kill_end", 0, fetch_kill_out);
    chk("refused_acc", 8'h00, accumulator_reg_out);
    chk("refused_zwe", 0, zero_flag_we_out);
    go(OP_SKIP_ZCOPY, 8'h80, 3'h0); chk("kill", 0, fetch_kill_out);
    chk("acc", 8'h80, accumulator_reg_out);
    go(OP_SKIP_BIT, 8'hf7, 3'h3); chk("kill", 1, fetch_kill_out);
    chk("zwe", 0, zero_flag_we_out);
    go(OP_SKIP_BIT, 8'h08, 3'h3); chk("kill", 0, fetch_kill_out);
    $display("skip test done");
  endtask
  task t_table;
    pc_page_in = 8'h12; table_pointer_high_in = 8'h34;
    tab(OP_TAB_CUR, 16'h1200, 16'ha55a);
    tab(OP_TAB_LAST, {LAST_PAGE, 8'h00}, 16'h0ff0);
    tab(OP_TAB_INC, 16'h3401, 16'h1234);
    tab(OP_TAB_INC_LST, {LAST_PAGE, 8'h02}, 16'h8001);
    for (int i = 3; i < 257; i++) tab(OP_TAB_INC, {8'h34, i[7:0]}, i[15:0]);
    chk("tpl", 8'h00, table_pointer_low_out);
    $display("table test done");
  endtask
  task t_xor;
    go(OP_XOR_ACC, 8'h81, 3'h0); chk("acc", 8'h01, accumulator_reg_out);
    chk("zwe", 1, zero_flag_we_out); chk("z", 0, zero_flag_out);
    go(OP_XOR_ACC, 8'h01, 3'h0); chk("z", 1, zero_flag_out);
    go(OP_XOR_MEM, 8'h3c, 3'h0); chk("wdata", 8'h3c, mem_wdata_out);
    chk("we", 1, mem_we_out); chk("acc", 8'h00, accumulator_reg_out); chk("z", 0, zero_flag_out);
    $display("xor test done");
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge ref_clk_in);
    rst_in = 0;
    t_skip; t_table; t_xor;
    print_verdict;
  end
  // tests need about 800 cycles
  initial begin
    #50000;
    error_cnt++;
    print_verdict;
  end
endmodule // estx_exec_tb_top
